// ==== logic/lsrc_top.sv ====
// register bank for two load switch / regulator channels
// Summary of operation
// RULE_01: config bit 5 of switch one picks load switch (0) or regulator three (1).
// RULE_02: switch one function bit resets to 0 on variant 0, else 1.
// RULE_03: five-bit code maps 1.50-2.50 V irregularly, then 2.55-3.30 V by 0.05 V.
// RULE_04: config bit 5 of switch two picks load switch (0) or regulator four (1).
// RULE_05: switch two function bit resets to 0 on variant 0, else 1.
// RULE_06: regulator four code acts only while its function bit is 1, same map.
// RULE_07: switch two config at 0x15 accepts writes only once unlocked.
// RULE_08: switch one config at 0x14 accepts writes only once unlocked.
// RULE_09: a channel is on only with its enable bit set and power enable high.
// RULE_10: bits 7 and 6 of both configs stay zero whatever is written.
`timescale 1ns/1ps
module lsrc_top
	import lsrc_pkg::*;
#(
	parameter int VARIANT = 0
)(
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	input  wire logic             unlocked,
	output logic      [7:0]       reg_rdata,
	output logic                  reg_wr_ack,
	// power path
	input  wire logic             power_enable_pin,
	output lsrc_mode_t            load_switch_one_mode,
	output logic      [9:0]       regulator3_level,
	output lsrc_mode_t            load_switch_two_mode,
	output logic      [9:0]       regulator4_level
);
	// RULE_02 variant reset
	localparam logic [7:0] SW1_RST = (VARIANT == 0) ? LSRC_SW1_RST_V0 :
		(VARIANT == 1) ? LSRC_SW1_RST_V1 : LSRC_SW1_RST_V23;
	// RULE_05 variant reset
	localparam logic [7:0] SW2_RST = (VARIANT == 0) ? LSRC_SW2_RST_V0 :
		LSRC_SW2_RST_V123;

	logic [7:0] load_switch1_config_q, load_switch1_config_d;
	logic [7:0] load_switch2_config_q, load_switch2_config_d;
	logic [7:0] enable_q, enable_d;
	logic [7:0] rdata_d;
	logic       ack_d;

	always_comb begin
		load_switch1_config_d = load_switch1_config_q;
		load_switch2_config_d = load_switch2_config_q;
		enable_d = enable_q;
		ack_d = 1'b0;
		rdata_d = reg_rdata;
		if (reg_wr && unlocked) begin
			case (reg_addr)
				// RULE_08 protected write
				LSRC_ADDR_SW1: begin
					// RULE_10 unused bits zero
					load_switch1_config_d = reg_wdata & LSRC_CFG_MASK;
					ack_d = 1'b1;
				end
				// RULE_07 protected write
				LSRC_ADDR_SW2: begin
					load_switch2_config_d = reg_wdata & LSRC_CFG_MASK;
					ack_d = 1'b1;
				end
				LSRC_ADDR_ENABLE: begin
					enable_d = reg_wdata;
					ack_d = 1'b1;
				end
				default: ack_d = 1'b0;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				LSRC_ADDR_SW1:    rdata_d = load_switch1_config_q;
				LSRC_ADDR_SW2:    rdata_d = load_switch2_config_q;
				LSRC_ADDR_ENABLE: rdata_d = enable_q;
				default:          rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			load_switch1_config_q <= SW1_RST;
			load_switch2_config_q <= SW2_RST;
			enable_q <= LSRC_ENABLE_RST;
			reg_rdata <= 8'h00;
			reg_wr_ack <= 1'b0;
		end else begin
			load_switch1_config_q <= load_switch1_config_d;
			load_switch2_config_q <= load_switch2_config_d;
			enable_q <= enable_d;
			reg_rdata <= rdata_d;
			reg_wr_ack <= ack_d;
		end
	end

	// per-channel configuration, enable and results
	logic       [7:0] ch_cfg   [2];
	logic             ch_en    [2];
	lsrc_mode_t       ch_mode  [2];
	logic       [9:0] ch_level [2];

	assign ch_cfg[0] = load_switch1_config_q;
	assign ch_cfg[1] = load_switch2_config_q;
	// RULE_09 enable bit select
	assign ch_en[0]  = enable_q[LSRC_EN_SW1_BIT];
	assign ch_en[1]  = enable_q[LSRC_EN_SW2_BIT];

	// RULE_01 switch one decode
	// RULE_04 switch two decode
	for (genvar i = 0; i < 2; i++) begin : g_ch
		lsrc_channel u_ch (
			.mclk             (mclk),
			.resetn           (resetn),
			.cfg              (ch_cfg[i]),
			.en_bit           (ch_en[i]),
			.power_enable_pin (power_enable_pin),
			.mode_q           (ch_mode[i]),
			.level_q          (ch_level[i])
		);
	end

	// outputs straight from channel flops
	assign load_switch_one_mode = ch_mode[0];
	assign regulator3_level     = ch_level[0];
	assign load_switch_two_mode = ch_mode[1];
	assign regulator4_level     = ch_level[1];
endmodule

// ==== logic/lsrc_pkg.sv ====
// constants and types for the load switch / regulator configuration block
package lsrc_pkg;
	localparam logic [7:0] LSRC_ADDR_SW1       = 8'h14;
	localparam logic [7:0] LSRC_ADDR_SW2       = 8'h15;
	localparam logic [7:0] LSRC_ADDR_ENABLE    = 8'h16;
	localparam int         LSRC_FSEL_BIT       = 5;
	localparam int         LSRC_CODE_W         = 5;
	localparam int         LSRC_EN_SW1_BIT     = 6;
	localparam int         LSRC_EN_SW2_BIT     = 5;
	localparam logic [7:0] LSRC_CFG_MASK       = 8'h3f;
	// reset images per factory variant, index 0 is the first variant
	localparam logic [7:0] LSRC_SW1_RST_V0     = 8'h06;
	localparam logic [7:0] LSRC_SW1_RST_V1     = 8'h3f;
	localparam logic [7:0] LSRC_SW1_RST_V23    = 8'h26;
	localparam logic [7:0] LSRC_SW2_RST_V0     = 8'h15;
	localparam logic [7:0] LSRC_SW2_RST_V123   = 8'h3f;
	localparam logic [7:0] LSRC_ENABLE_RST     = 8'h00;
	// output level in units of 10 mV for each regulator code
	localparam logic [9:0] LSRC_MV10_LO [16] = '{
		10'd150, 10'd155, 10'd160, 10'd165, 10'd170, 10'd175, 10'd180,
		10'd185, 10'd190, 10'd200, 10'd210, 10'd220, 10'd230, 10'd240,
		10'd245, 10'd250};
	localparam logic [9:0] LSRC_MV10_HI_BASE   = 10'd255;
	localparam logic [9:0] LSRC_MV10_HI_STEP   = 10'd5;
	typedef enum logic [1:0] {
		LSRC_MODE_OFF,
		LSRC_MODE_SWITCH,
		LSRC_MODE_REGULATOR
	} lsrc_mode_t;
endpackage

// ==== logic/lsrc_channel.sv ====
// one power-path channel: mode decode and level lookup
`timescale 1ns/1ps
module lsrc_channel
	import lsrc_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   resetn,
	// configuration
	input  wire logic [7:0]             cfg,
	input  wire logic                   en_bit,
	input  wire logic                   power_enable_pin,
	// channel state
	output lsrc_mode_t                  mode_q,
	output logic       [9:0]            level_q
);
	lsrc_mode_t mode_d;
	logic [9:0] level_d;
	logic [LSRC_CODE_W-1:0] code;

	always_comb begin
		code = cfg[LSRC_CODE_W-1:0];
		mode_d = LSRC_MODE_OFF;
		level_d = 10'd0;
		// RULE_09 enable and pin
		if (en_bit && power_enable_pin) begin
			// RULE_06 code only as regulator
			if (cfg[LSRC_FSEL_BIT]) begin
				mode_d = LSRC_MODE_REGULATOR;
				// RULE_03 level lookup
				if (code[4])
					level_d = LSRC_MV10_HI_BASE +
						LSRC_MV10_HI_STEP * {6'd0, code[3:0]};
				else
					level_d = LSRC_MV10_LO[code[3:0]];
			end else begin
				mode_d = LSRC_MODE_SWITCH;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			mode_q <= LSRC_MODE_OFF;
			level_q <= 10'd0;
		end else begin
			mode_q <= mode_d;
			level_q <= level_d;
		end
	end
endmodule

// ==== sim/lsrc_checker.sv ====
// port assertions for the load switch register bank
`timescale 1ns/1ps
module lsrc_checker
	import lsrc_pkg::*;
(
	input wire logic       mclk, resetn, reg_wr, reg_rd, unlocked,
	input wire logic       reg_wr_ack, power_enable_pin,
	input wire logic [7:0] reg_addr, reg_rdata,
	input lsrc_mode_t      load_switch_one_mode, load_switch_two_mode,
	input wire logic [9:0] regulator3_level, regulator4_level
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	chk_write_ack: assert property (reg_wr && unlocked &&
		reg_addr[7:1] == 7'h0a |=> reg_wr_ack) else $error("no ack");
	chk_locked_write: assert property (reg_wr && !unlocked
		|=> !reg_wr_ack) else $error("locked write acked");
	chk_ack_cause: assert property (reg_wr_ack
		|-> $past(reg_wr) && $past(unlocked)) else $error("stray ack");
	chk_top_bits: assert property (reg_rd && reg_addr[7:1] == 7'h0a
		|=> reg_rdata[7:6] == 2'h0) else $error("top bits set");
	chk_pin_off: assert property (!power_enable_pin [*2]
		|=> load_switch_two_mode == LSRC_MODE_OFF) else $error("on, pin low");
	chk_sw1_level: assert property (
		load_switch_one_mode != LSRC_MODE_REGULATOR |-> !regulator3_level)
		else $error("level three set");
	chk_sw2_level: assert property (
		load_switch_two_mode != LSRC_MODE_REGULATOR |-> !regulator4_level)
		else $error("level four set");
	chk_level_range: assert property (
		load_switch_two_mode == LSRC_MODE_REGULATOR |->
		regulator4_level inside {[10'h096:10'h14a]}) else $error("range");
endmodule
bind lsrc_top lsrc_checker u_chk (.mclk, .resetn, .reg_wr, .reg_rd,
	.unlocked, .reg_wr_ack, .power_enable_pin, .reg_addr, .reg_rdata,
	.load_switch_one_mode, .load_switch_two_mode, .regulator3_level,
	.regulator4_level);

// ==== sim/lsrc_host.sv ====
// host model driving the register port
`timescale 1ns/1ps
module lsrc_host (
	input  wire logic  mclk,
	output logic [7:0] reg_addr, reg_wdata,
	output logic       reg_wr, reg_rd, unlocked
);
	initial {reg_addr, reg_wdata, reg_wr, reg_rd, unlocked} = '0;
	task automatic xfer(logic wr, logic unl, logic [7:0] a, logic [7:0] d);
		@(negedge mclk);
		{reg_wr, reg_rd, unlocked, reg_addr, reg_wdata} = {wr, !wr, unl, a, d};
		@(negedge mclk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
	endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the load switch register bank
`timescale 1ns/1ps
module testbench;
	import lsrc_pkg::*;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v, expq [$];
	logic       mclk = 0, resetn = 0, reg_wr, reg_rd, unlocked, reg_wr_ack;
	logic       power_enable_pin = 0, rd_d = 0, wr_d = 0, ackq [$];
	lsrc_mode_t m1, m2;
	logic [9:0] l3, l4;
	int         num_errors = 0, comparisons = 0, cyc = 0;
	initial forever #12.5 mclk = ~mclk;
	lsrc_host i_host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.unlocked);
	lsrc_top #(.VARIANT(1)) i_dut (.mclk, .resetn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .unlocked, .reg_rdata, .reg_wr_ack,
		.power_enable_pin, .load_switch_one_mode(m1), .regulator3_level(l3),
		.load_switch_two_mode(m2), .regulator4_level(l4));
	task automatic cmp_level(string n, logic [9:0] e, logic [9:0] s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_mode(string n, lsrc_mode_t e, lsrc_mode_t s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp_rd(logic [7:0] e);
		comparisons++;
		if (reg_rdata !== e) begin
			num_errors++;
			$display("CHECK FAILED reg_rdata expected %h seen %h", e,
				reg_rdata);
		end
	endtask
	task automatic cmp_ack(logic e);
		comparisons++;
		if (reg_wr_ack !== e) begin
			num_errors++;
			$display("CHECK FAILED reg_wr_ack expected %h seen %h", e,
				reg_wr_ack);
		end
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		expq.push_back(e);
		i_host.xfer(0, 0, a, 8'h00);
	endtask
	task automatic wr(logic unl, logic [7:0] a, logic [7:0] d);
		ackq.push_back(unl);
		i_host.xfer(1, unl, a, d);
	endtask
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		rd_d <= reg_rd;
		wr_d <= reg_wr;
		cyc <= cyc + 1;
		if (rd_d) cmp_rd(expq.pop_front());
		if (wr_d) cmp_ack(ackq.pop_front());
		if (cyc == 3000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		void'($urandom(66164));
		repeat (8) @(negedge mclk);
		resetn = 1;
		rd(LSRC_ADDR_SW1, LSRC_SW1_RST_V1);
		rd(LSRC_ADDR_SW2, LSRC_SW2_RST_V123);
		wr(0, LSRC_ADDR_SW2, 8'h00);
		rd(LSRC_ADDR_SW2, LSRC_SW2_RST_V123);
		v = 8'($urandom);
		wr(1, LSRC_ADDR_SW1, v);
		rd(LSRC_ADDR_SW1, v & LSRC_CFG_MASK);
		rd(8'h20, 8'h00);
		power_enable_pin = 1;
		wr(1, LSRC_ADDR_ENABLE, 8'h60);
		for (int c = 0; c < 32; c++) begin
			wr(1, LSRC_ADDR_SW2, 8'h20 | 8'(c));
			wr(1, LSRC_ADDR_SW1, 8'hc0 | 8'(c));
			repeat (2) @(negedge mclk);
			cmp_level("level4", c < 16 ? LSRC_MV10_LO[c] :
				10'(LSRC_MV10_HI_BASE + LSRC_MV10_HI_STEP * (c - 16)), l4);
			cmp_mode("mode2", LSRC_MODE_REGULATOR, m2);
			cmp_mode("mode1", LSRC_MODE_SWITCH, m1);
			cmp_level("level3", 10'd0, l3);
		end
		rd(LSRC_ADDR_SW1, 8'h1f);
		power_enable_pin = 0;
		repeat (3) @(negedge mclk);
		cmp_mode("mode2", LSRC_MODE_OFF, m2);
		cmp_mode("mode1", LSRC_MODE_OFF, m1);
		power_enable_pin = 1;
		wr(1, LSRC_ADDR_SW2, 8'h1f);
		wr(1, LSRC_ADDR_SW1, 8'hff);
		repeat (2) @(negedge mclk);
		cmp_mode("mode2", LSRC_MODE_SWITCH, m2);
		cmp_level("level4", 10'd0, l4);
		cmp_mode("mode1", LSRC_MODE_REGULATOR, m1);
		cmp_level("level3",
			10'(LSRC_MV10_HI_BASE + LSRC_MV10_HI_STEP * 15), l3);
		resetn = 0;
		repeat (2) @(negedge mclk);
		resetn = 1;
		rd(LSRC_ADDR_SW2, LSRC_SW2_RST_V123);
		rd(LSRC_ADDR_SW1, LSRC_SW1_RST_V1);
		repeat (2) @(negedge mclk);
		cmp_mode("mode1", LSRC_MODE_OFF, m1);
		results();
	end
endmodule
